// ---- logic/aon_analog_pkg.sv ----
// Constants and types for the always-on analog control register bank.
package aon_analog_pkg;
  localparam int REG_N = 6;
  localparam int CODE_W = 14;
  localparam int REG_CAL = 0;
  localparam int REG_XTAL = 1;
  localparam int REG_CMP = 2;
  localparam int REG_AR = 3;
  localparam int REG_BT = 4;
  localparam int REG_CR = 5;
  localparam logic [11:0] REG_OFF [REG_N] = '{
    12'h0BC, 12'h0C0, 12'h0C4, 12'h0C8, 12'h0D0, 12'h0D4};
  localparam logic [31:0] RW_MASK [REG_N] = '{
    32'h00FC0000, 32'h00007E7C, 32'h000003FC,
    32'h000FFC00, 32'h000FF000, 32'h00007F9F};
  localparam logic [31:0] RST_VAL [REG_N] = '{
    32'h00180000, 32'h00000204, 32'h00000100,
    32'h00012800, 32'h0004A000, 32'h00002510};
  localparam int CAL_EXT_BIT = 23;
  localparam int CAL_DIV_LO = 19;
  localparam int CAL_DIV_W = 3;
  localparam int CAL_PERMIT_BIT = 18;
  localparam int CAL_CODE_LO = 4;
  localparam int CAL_RUN_BIT = 3;
  localparam int CAL_LVL_BIT = 2;
  localparam int CAL_RDY_BIT = 1;
  localparam int CAL_DONE_BIT = 0;
  localparam int XT_EN_BIT = 12;
  localparam int XT_EXT_BIT = 11;
  localparam int XT_ASSIST_LO = 2;
  localparam int XT_LVL_BIT = 1;
  localparam int XT_RDY_BIT = 0;
  localparam int CMP_HYST_LO = 7;
  localparam int CMP_EN_BIT = 6;
  localparam int CMP_DIFF_BIT = 5;
  localparam int CMP_REF_LO = 2;
  localparam int CMP_RDY_BIT = 1;
  localparam int CMP_OUT_BIT = 0;
  localparam int AR_EN_BIT = 17;
  localparam int AR_RDY_BIT = 9;
  localparam int AR_OUT_BIT = 8;
  localparam int BT_EN_BIT = 19;
  localparam int BT_TRIG_LO = 16;
  localparam int BT_RDY_BIT = 11;
  localparam int BT_OUT_BIT = 10;
  localparam int CR_EN_BIT = 14;
  localparam int CR_FILT_LO = 7;
  localparam int CR_RDY_BIT = 6;
  localparam int CR_OUT_BIT = 5;

  typedef struct packed {
    logic [31:0] slow_osc;
    logic [31:0] crystal;
    logic [31:0] comparator;
    logic [31:0] analog_rail;
    logic [31:0] battery;
    logic [31:0] core_rail;
  } analog_ctrl_t;

  typedef struct packed {
    logic [CODE_W-1:0] slow_osc_calibrated_code;
    logic slow_osc_cal_running;
    logic slow_osc_level;
    logic slow_osc_ready;
    logic slow_osc_cal_complete;
    logic crystal_level;
    logic crystal_osc_ready;
    logic comparator_ready;
    logic comparator_output;
    logic analog_rail_detector_ready;
    logic analog_rail_brownout_flag;
    logic battery_detector_ready;
    logic battery_brownout_flag;
    logic core_rail_detector_ready;
    logic core_rail_brownout_flag;
  } analog_stat_t;
endpackage

// ---- logic/aon_analog_ctrl_regs.sv ----
// Register bank for the always-on oscillators, comparator and detectors.
module aon_analog_ctrl_regs
  import aon_analog_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  output analog_ctrl_t ctrl,
  input wire analog_stat_t stat_in
);

  localparam int SW = $bits(analog_stat_t);

  // Fewer than eight address bits would alias the register offsets.
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must lie between 8 and 32.");
  end

  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] a,
    input int i
  );
    reg_hit = (a == ADDR_W'(REG_OFF[i]));
  endfunction

  // Every bit that carries a field in a register; all others read zero.
  function automatic logic [31:0] live_bits(input int i);
    logic [31:0] m;
    m = RW_MASK[i];
    case (i)
      REG_CAL: begin
        m[CAL_CODE_LO +: CODE_W] = {CODE_W{1'b1}};
        m[CAL_RUN_BIT] = 1'b1;
        m[CAL_LVL_BIT] = 1'b1;
        m[CAL_RDY_BIT] = 1'b1;
        m[CAL_DONE_BIT] = 1'b1;
      end
      REG_XTAL: begin
        m[XT_LVL_BIT] = 1'b1;
        m[XT_RDY_BIT] = 1'b1;
      end
      REG_CMP: begin
        m[CMP_RDY_BIT] = 1'b1;
        m[CMP_OUT_BIT] = 1'b1;
      end
      REG_AR: begin
        m[AR_RDY_BIT] = 1'b1;
        m[AR_OUT_BIT] = 1'b1;
      end
      REG_BT: begin
        m[BT_RDY_BIT] = 1'b1;
        m[BT_OUT_BIT] = 1'b1;
      end
      REG_CR: begin
        m[CR_RDY_BIT] = 1'b1;
        m[CR_OUT_BIT] = 1'b1;
      end
      default: m = 32'h00000000;
    endcase
    return m;
  endfunction

  // Analog status arrives with no relation to this clock.
  // Three stages, and a change is taken only once the last two agree.
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  logic [SW-1:0] s3_r;
  logic [SW-1:0] st_r;
  logic [SW-1:0] st_nxt;
  logic [SW-1:0] agree;
  analog_stat_t st;

  assign agree = ~(s2_r ^ s3_r);
  assign st_nxt = (st_r & ~agree) | (s3_r & agree);
  assign st = analog_stat_t'(st_r);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      st_r <= '0;
    end else if (ce) begin
      s1_r <= stat_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      st_r <= st_nxt;
    end
  end

  // The code is caught only as completion rises, so a code that
  // moves during a new run never shows as a finished result.
  logic done_d_r;
  logic [CODE_W-1:0] code_r;
  logic [CODE_W-1:0] code_nxt;
  logic done_rise;

  assign done_rise = st.slow_osc_cal_complete && !done_d_r;
  assign code_nxt = done_rise ? st.slow_osc_calibrated_code : code_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      done_d_r <= 1'b0;
      code_r <= '0;
    end else if (ce) begin
      done_d_r <= st.slow_osc_cal_complete;
      code_r <= code_nxt;
    end
  end

  // Control registers keep only their writable bits, so reserved
  // bits always read back as zero whatever software wrote.
  logic [REG_N-1:0] hit;
  logic [31:0] ctl_r [REG_N];
  logic [31:0] ctl_nxt [REG_N];
  logic [31:0] stat_word [REG_N];
  logic [31:0] rd_part [REG_N];
  logic [31:0] rd_acc [REG_N+1];
  logic [31:0] live_acc [REG_N+1];

  genvar gi;
  generate
    for (gi = 0; gi < REG_N; gi++) begin : g_reg
      assign hit[gi] = reg_hit(addr, gi);
      assign ctl_nxt[gi] = wdata & RW_MASK[gi];
      assign rd_part[gi] = hit[gi] ?
        (ctl_r[gi] | stat_word[gi]) : 32'h00000000;
      assign rd_acc[gi+1] = rd_acc[gi] | rd_part[gi];
      assign live_acc[gi+1] = live_acc[gi] |
        (hit[gi] ? live_bits(gi) : 32'h00000000);
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          ctl_r[gi] <= RST_VAL[gi];
        end else if (ce && wr_stb && hit[gi]) begin
          ctl_r[gi] <= ctl_nxt[gi];
        end
      end
    end
  endgenerate

  assign rd_acc[0] = 32'h00000000;
  assign live_acc[0] = 32'h00000000;

  always_comb begin
    stat_word[REG_CAL] = 32'h00000000;
    stat_word[REG_CAL][CAL_CODE_LO +: CODE_W] = code_r;
    stat_word[REG_CAL][CAL_RUN_BIT] = st.slow_osc_cal_running;
    stat_word[REG_CAL][CAL_LVL_BIT] = st.slow_osc_level;
    stat_word[REG_CAL][CAL_RDY_BIT] = st.slow_osc_ready;
    stat_word[REG_CAL][CAL_DONE_BIT] = st.slow_osc_cal_complete;
    stat_word[REG_XTAL] = 32'h00000000;
    stat_word[REG_XTAL][XT_LVL_BIT] = st.crystal_level;
    stat_word[REG_XTAL][XT_RDY_BIT] = st.crystal_osc_ready;
    stat_word[REG_CMP] = 32'h00000000;
    stat_word[REG_CMP][CMP_RDY_BIT] = st.comparator_ready;
    stat_word[REG_CMP][CMP_OUT_BIT] = st.comparator_output;
    stat_word[REG_AR] = 32'h00000000;
    stat_word[REG_AR][AR_RDY_BIT] = st.analog_rail_detector_ready;
    stat_word[REG_AR][AR_OUT_BIT] = st.analog_rail_brownout_flag;
    stat_word[REG_BT] = 32'h00000000;
    stat_word[REG_BT][BT_RDY_BIT] = st.battery_detector_ready;
    stat_word[REG_BT][BT_OUT_BIT] = st.battery_brownout_flag;
    stat_word[REG_CR] = 32'h00000000;
    stat_word[REG_CR][CR_RDY_BIT] = st.core_rail_detector_ready;
    stat_word[REG_CR][CR_OUT_BIT] = st.core_rail_brownout_flag;
  end

  // Read data stand only in the cycle after the strobe; an unmapped
  // address falls out of every term and reads as zero.
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  assign rdata_nxt = rd_stb ? rd_acc[REG_N] : 32'h00000000;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 32'h00000000;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  // Each control word goes to the analog side straight from its flop.
  assign ctrl.slow_osc = ctl_r[REG_CAL];
  assign ctrl.crystal = ctl_r[REG_XTAL];
  assign ctrl.comparator = ctl_r[REG_CMP];
  assign ctrl.analog_rail = ctl_r[REG_AR];
  assign ctrl.battery = ctl_r[REG_BT];
  assign ctrl.core_rail = ctl_r[REG_CR];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  sequence s_wr(int i);
    ce && wr_stb && hit[i];
  endsequence

  sequence s_rd(int i);
    ce && rd_stb && hit[i];
  endsequence

  a_ext_code_write: assert property (
    s_wr(REG_CAL) |=> ctrl.slow_osc[CAL_EXT_BIT] ==
      $past(wdata[CAL_EXT_BIT]))
    else $error("External code enable missed its write.");

  a_cal_step_div: assert property (
    s_wr(REG_CAL) |=> ctrl.slow_osc[CAL_DIV_LO +: CAL_DIV_W] ==
      $past(wdata[CAL_DIV_LO +: CAL_DIV_W]))
    else $error("Calibration step divider missed its write.");

  a_cal_permit_hold: assert property (
    !(ce && wr_stb && hit[REG_CAL]) |=>
      $stable(ctrl.slow_osc[CAL_PERMIT_BIT]))
    else $error("Calibration permit changed without a write.");

  a_code_capture: assert property (
    ce && done_rise ##1 s_rd(REG_CAL) |=>
      rdata[CAL_CODE_LO +: CODE_W] ==
      $past(st.slow_osc_calibrated_code, 2))
    else $error("Calibrated code not captured at completion.");

  a_running_read: assert property (
    s_rd(REG_CAL) |=>
      rdata[CAL_RUN_BIT] == $past(st.slow_osc_cal_running))
    else $error("Calibration running bit misread.");

  a_osc_ready_read: assert property (
    s_rd(REG_CAL) |=> rdata[CAL_RDY_BIT] == $past(st.slow_osc_ready))
    else $error("Slow oscillator ready bit misread.");

  a_cal_done_read: assert property (
    s_rd(REG_CAL) |=>
      rdata[CAL_DONE_BIT] == $past(st.slow_osc_cal_complete))
    else $error("Calibration complete bit misread.");

  a_crystal_mode: assert property (
    s_wr(REG_XTAL) |=>
      ctrl.crystal[XT_EXT_BIT] == $past(wdata[XT_EXT_BIT]) &&
      ctrl.crystal[XT_EN_BIT] == $past(wdata[XT_EN_BIT]))
    else $error("Crystal mode or enable missed its write.");

  a_crystal_ready: assert property (
    s_rd(REG_XTAL) |=>
      rdata[XT_RDY_BIT] == $past(st.crystal_osc_ready))
    else $error("Crystal ready bit misread.");

  a_assist_write: assert property (
    s_wr(REG_XTAL) |=> ctrl.crystal[XT_ASSIST_LO +: 2] ==
      $past(wdata[XT_ASSIST_LO +: 2]))
    else $error("Startup assist field missed its write.");

  a_ref_select: assert property (
    s_wr(REG_CMP) |=> ctrl.comparator[CMP_REF_LO +: 3] ==
      $past(wdata[CMP_REF_LO +: 3]))
    else $error("Comparator reference select missed its write.");

  a_cmp_enable: assert property (
    s_wr(REG_CMP) |=>
      ctrl.comparator[CMP_EN_BIT] == $past(wdata[CMP_EN_BIT]) &&
      ctrl.comparator[CMP_HYST_LO +: 2] ==
      $past(wdata[CMP_HYST_LO +: 2]))
    else $error("Comparator enable or hysteresis missed its write.");

  a_cmp_diff: assert property (
    s_wr(REG_CMP) |=>
      ctrl.comparator[CMP_DIFF_BIT] == $past(wdata[CMP_DIFF_BIT]))
    else $error("Differential select missed its write.");

  a_cmp_status: assert property (
    s_rd(REG_CMP) |=>
      rdata[CMP_RDY_BIT] == $past(st.comparator_ready) &&
      rdata[CMP_OUT_BIT] == $past(st.comparator_output))
    else $error("Comparator status misread.");

  a_rail_status: assert property (
    s_rd(REG_AR) |=>
      rdata[AR_OUT_BIT] == $past(st.analog_rail_brownout_flag) &&
      rdata[AR_RDY_BIT] == $past(st.analog_rail_detector_ready))
    else $error("Analog rail detector status misread.");

  a_battery_status: assert property (
    s_rd(REG_BT) |=>
      rdata[BT_OUT_BIT] == $past(st.battery_brownout_flag) &&
      rdata[BT_RDY_BIT] == $past(st.battery_detector_ready))
    else $error("Battery detector status misread.");

  a_battery_enable: assert property (
    s_wr(REG_BT) |=>
      ctrl.battery[BT_EN_BIT] == $past(wdata[BT_EN_BIT]) &&
      ctrl.battery[BT_TRIG_LO +: 3] == $past(wdata[BT_TRIG_LO +: 3]))
    else $error("Battery detector controls missed their write.");

  a_core_status: assert property (
    s_rd(REG_CR) |=>
      rdata[CR_OUT_BIT] == $past(st.core_rail_brownout_flag) &&
      rdata[CR_RDY_BIT] == $past(st.core_rail_detector_ready))
    else $error("Core rail detector status misread.");

  a_core_enable: assert property (
    s_wr(REG_CR) |=>
      ctrl.core_rail[CR_EN_BIT] == $past(wdata[CR_EN_BIT]) &&
      ctrl.core_rail[CR_FILT_LO +: 2] == $past(wdata[CR_FILT_LO +: 2]))
    else $error("Core rail detector controls missed their write.");

  a_sync_settle: assert property (
    (ce && $stable(stat_in))[*4] |-> st_r == stat_in)
    else $error("Status did not settle three stages after input.");

  // A visible status bit may only take a value that stood at the input
  // in two samples in a row, three and four cycles back.
  a_sync_hold: assert property (
    ce [*5] |-> ((st_r ^ $past(st_r)) &
      ((st_r ^ $past(stat_in, 3)) | (st_r ^ $past(stat_in, 4)))) ==
      '0)
    else $error("Status moved before the last two stages agreed.");

  a_read_once: assert property (
    ce && !rd_stb |=> rdata == 32'h00000000)
    else $error("Read data stood outside the answer cycle.");

  a_reserved_zero: assert property (
    ce && rd_stb |=> (rdata & ~$past(live_acc[REG_N])) == 32'h00000000)
    else $error("Reserved or unmapped bits read nonzero.");

  a_ctrl_reserved: assert property (
    ((ctrl.slow_osc & ~RW_MASK[REG_CAL]) |
      (ctrl.crystal & ~RW_MASK[REG_XTAL]) |
      (ctrl.comparator & ~RW_MASK[REG_CMP]) |
      (ctrl.analog_rail & ~RW_MASK[REG_AR]) |
      (ctrl.battery & ~RW_MASK[REG_BT]) |
      (ctrl.core_rail & ~RW_MASK[REG_CR])) == 32'h00000000)
    else $error("A control word drove a reserved bit.");

  a_code_take: assert property (
    ce && done_rise |=> code_r == $past(st.slow_osc_calibrated_code))
    else $error("Calibrated code not taken as calibration completed.");

  a_code_hold: assert property (
    !(ce && done_rise) |=> $stable(code_r))
    else $error("Calibrated code moved without a completion.");

  a_permit_write: assert property (
    s_wr(REG_CAL) |=>
      ctrl.slow_osc[CAL_PERMIT_BIT] == $past(wdata[CAL_PERMIT_BIT]))
    else $error("Calibration permit missed its write.");

  a_rail_enable: assert property (
    s_wr(REG_AR) |=>
      ctrl.analog_rail[AR_EN_BIT] == $past(wdata[AR_EN_BIT]))
    else $error("Analog rail detector enable missed its write.");

  a_ctrl_quiet: assert property (
    !(ce && wr_stb) |=> $stable(ctrl))
    else $error("A control word moved without a write.");

  a_unmapped_write: assert property (
    ce && wr_stb && hit == '0 |=> $stable(ctrl))
    else $error("A write to an unmapped address changed a control word.");

  a_ce_freeze: assert property (
    !ce |=> $stable(rdata) && $stable(ctrl) && $stable(code_r))
    else $error("State moved while the clock enable was low.");

  a_reset_state: assert property (
    $rose(arst_n) |-> rdata == 32'h00000000 && code_r == '0 &&
      ctrl == {RST_VAL[REG_CAL], RST_VAL[REG_XTAL], RST_VAL[REG_CMP],
      RST_VAL[REG_AR], RST_VAL[REG_BT], RST_VAL[REG_CR]})
    else $error("Register bank left reset with wrong values.");

endmodule // aon_analog_ctrl_regs

// ---- bench/analog_partner.sv ----
// Behavioural model of the always-on oscillators, comparator and detectors.
module analog_partner
  import aon_analog_pkg::*;
#(
  parameter int CAL_LEN = 20
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire analog_ctrl_t ctrl,
  input wire logic cmp_in,
  input wire logic [2:0] fault,
  input wire logic [CODE_W-1:0] cal_code,
  output analog_stat_t stat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] boot_r;
  logic [5:0] cal_cnt_r;
  logic permit_d_r, run_r, done_r;
  logic [CODE_W-1:0] code_r;
  logic [4:0] rdy_r;
  wire logic permit = ctrl.slow_osc[CAL_PERMIT_BIT];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      boot_r <= 5'h00;
      cal_cnt_r <= 6'h00;
      {permit_d_r, run_r, done_r} <= 3'h0;
      code_r <= '0;
      rdy_r <= 5'h00;
    end else begin
      if (boot_r != 5'h10) boot_r <= boot_r + 5'h01;
      permit_d_r <= permit;
      rdy_r <= {ctrl.crystal[XT_EN_BIT] | ctrl.crystal[XT_EXT_BIT],
        ctrl.comparator[CMP_EN_BIT], ctrl.analog_rail[AR_EN_BIT],
        ctrl.battery[BT_EN_BIT], ctrl.core_rail[CR_EN_BIT]};
      // The code settles before completion so it never races the flag.
      if (permit && !permit_d_r) begin
        run_r <= 1'b1;
        done_r <= 1'b0;
        cal_cnt_r <= 6'(CAL_LEN);
        code_r <= cal_code;
      end else if (run_r && cal_cnt_r == 6'h01) begin
        run_r <= 1'b0;
        done_r <= 1'b1;
      end else if (run_r) cal_cnt_r <= cal_cnt_r - 6'h01;
      if (!permit) {run_r, done_r} <= 2'h0;
    end
  end

  // The 32 kHz levels change far slower than a read, so they are held low.
  always_comb begin
    stat = '0;
    stat.slow_osc_calibrated_code = code_r;
    stat.slow_osc_cal_running = run_r;
    stat.slow_osc_ready = (boot_r == 5'h10);
    stat.slow_osc_cal_complete = done_r;
    stat.crystal_osc_ready = rdy_r[4];
    stat.comparator_ready = rdy_r[3];
    stat.comparator_output = rdy_r[3] & cmp_in;
    stat.analog_rail_detector_ready = rdy_r[2];
    stat.analog_rail_brownout_flag = rdy_r[2] & fault[0];
    stat.battery_detector_ready = rdy_r[1];
    stat.battery_brownout_flag = rdy_r[1] & fault[1];
    stat.core_rail_detector_ready = rdy_r[0];
    stat.core_rail_brownout_flag = rdy_r[0] & fault[2];
  end
endmodule // analog_partner

// ---- bench/tb.sv ----
// Self-checking bench for the always-on analog register bank.
module tb
  import aon_analog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, arst_n = 1'b0, ce = 1'b1, wr_stb = 1'b0;
  logic rd_stb = 1'b0, cmp_in = 1'b0, cal_done_exp = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata, v, d, e;
  logic [31:0] rng = 32'h000067B4;
  logic [2:0] fault = 3'h0;
  logic [CODE_W-1:0] cal_code = '0, code_exp = '0;
  logic [31:0] shadow [REG_N];
  analog_ctrl_t ctrl;
  analog_stat_t stat;
  int err_total = 0, num_checks = 0, i;

  always #12.5 clock = ~clock;

  aon_analog_ctrl_regs DUT (.clock(clock), .arst_n(arst_n), .ce(ce),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .ctrl(ctrl), .stat_in(stat));
  analog_partner model (.clock(clock), .arst_n(arst_n), .ctrl(ctrl),
    .cmp_in(cmp_in), .fault(fault), .cal_code(cal_code), .stat(stat));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [31:0] expect_rd(input int k);
    logic [31:0] x;
    x = shadow[k] & RW_MASK[k];
    case (k)
      REG_CAL: begin
        x[CAL_CODE_LO +: CODE_W] = code_exp;
        x[CAL_RDY_BIT] = 1'b1;
        x[CAL_DONE_BIT] = cal_done_exp;
      end
      REG_XTAL: x[XT_RDY_BIT] = x[XT_EN_BIT] | x[XT_EXT_BIT];
      REG_CMP: x[CMP_OUT_BIT +: 2] = {x[CMP_EN_BIT], x[CMP_EN_BIT] & cmp_in};
      REG_AR: x[AR_OUT_BIT +: 2] = {x[AR_EN_BIT], x[AR_EN_BIT] & fault[0]};
      REG_BT: x[BT_OUT_BIT +: 2] = {x[BT_EN_BIT], x[BT_EN_BIT] & fault[1]};
      default: x[CR_OUT_BIT +: 2] = {x[CR_EN_BIT], x[CR_EN_BIT] & fault[2]};
    endcase
    return x;
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic wr_a(input logic [11:0] a, input logic [31:0] dv);
    @(posedge clock);
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    addr <= a;
    wdata <= dv;
  endtask

  task automatic wr(input int k, input logic [31:0] dv);
    shadow[k] = dv;
    wr_a(REG_OFF[k], dv);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] dv);
    @(posedge clock);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 dv = rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock);
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
    end
  endtask

  task automatic check_all();
    for (int k = 0; k < REG_N; k++) begin
      rd(REG_OFF[k], v);
      check($sformatf("read %0d", k), v,
        expect_rd(k));
      check($sformatf("ctrl %0d", k), ctrl[32*(REG_N-1-k) +: 32],
        shadow[k] & RW_MASK[k]);
    end
  endtask

  task automatic reset_seq();
    @(posedge clock);
    arst_n <= 1'b0;
    idle(10);
    arst_n <= 1'b1;
    for (int k = 0; k < REG_N; k++) shadow[k] = RST_VAL[k];
    code_exp = '0;
    cal_done_exp = 1'b0;
    idle(30);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    conclude();
  end

  initial begin
    reset_seq();
    check_all();
    repeat (40) begin
      rng = nxt(rng);
      i = int'(rng[15:0] % 16'(REG_N));
      rng = nxt(rng);
      d = rng & RW_MASK[i];
      // Calibration is started only by its own scenario below.
      if (i == REG_CAL) d[CAL_PERMIT_BIT] = 1'b0;
      wr(i, d);
      rng = nxt(rng);
      cmp_in <= rng[0];
      fault <= rng[3:1];
      idle(8);
      check_all();
    end
    wr(REG_CMP, ~shadow[REG_CMP] & RW_MASK[REG_CMP]);
    rd(REG_OFF[REG_CMP], v);
    check("cmp after write", v & RW_MASK[REG_CMP],
      shadow[REG_CMP]);
    for (int k = 0; k < 2; k++) begin
      wr(REG_CAL, shadow[REG_CAL] | (32'h1 << CAL_PERMIT_BIT));
      rng = nxt(rng);
      cal_code <= rng[CODE_W-1:0];
      idle(8);
      rd(REG_OFF[REG_CAL], v);
      e = expect_rd(REG_CAL);
      e[CAL_RUN_BIT] = 1'b1;
      check("cal running", v, e);
      idle(30);
      code_exp = cal_code;
      cal_done_exp = 1'b1;
      check_all();
      wr(REG_CAL, shadow[REG_CAL] & ~(32'h1 << CAL_PERMIT_BIT));
      idle(8);
      cal_done_exp = 1'b0;
      check_all();
    end
    wr_a(12'h0CC, rng);
    rd(12'h0CC, v);
    check("unmapped", v, 32'h00000000);
    @(posedge clock);
    ce <= 1'b0;
    wr_a(REG_OFF[REG_XTAL], ~shadow[REG_XTAL] & RW_MASK[REG_XTAL]);
    idle(2);
    ce <= 1'b1;
    idle(8);
    check_all();
    reset_seq();
    check_all();
    conclude();
  end
endmodule // tb
